// ===== inc/lcr_pkg.sv
// Package of constants and types for the lane configuration register slice.
// Contract
// - Assert threshold code selects fixed millivolt level.
// - De-assert threshold code selects fixed millivolt level.
// - Threshold fields apply only under override bit.
// - Probe code 00 keeps input high impedance.
// - Code 01 probes every 12 ms, 50 times.
// - Code 10 probes every 12 ms until found.
// - Automatic modes terminate only after detection.
// - Probe field applies only under override bit.
// - Boost register eight bits, resets to 0x2f.
// - Swing bit 7 enables short protection.
// - Swing bits 2:0 select amplitude ratio.
// - Swing register resets to 0xad.
// - Read-only status bit 7 shows termination.
`default_nettype none
package lcr_pkg;
    localparam logic [7:0] LCR_ADDR_THRESH = 8'h20;
    localparam logic [7:0] LCR_ADDR_RSVD_LO = 8'h21;
    localparam logic [7:0] LCR_ADDR_RSVD_HI = 8'h22;
    localparam logic [7:0] LCR_ADDR_PROBE = 8'h23;
    localparam logic [7:0] LCR_ADDR_BOOST = 8'h24;
    localparam logic [7:0] LCR_ADDR_SWING = 8'h25;
    localparam logic [7:0] LCR_ADDR_STATUS = 8'h26;
    localparam logic [7:0] LCR_RST_THRESH = 8'h00;
    localparam logic [7:0] LCR_RST_PROBE = 8'h00;
    localparam logic [7:0] LCR_RST_BOOST = 8'h2f;
    localparam logic [7:0] LCR_RST_SWING = 8'had;
    localparam logic [7:0] LCR_RST_STATUS = 8'h02;
    localparam int LCR_POS_ASSERT = 2;
    localparam int LCR_POS_DEASSERT = 0;
    localparam int LCR_POS_PROBE = 2;
    localparam int LCR_POS_SHORT = 7;
    localparam int LCR_POS_DETECTED = 7;
    localparam int LCR_POS_OVR_THRESH = 6;
    localparam int LCR_POS_OVR_PROBE = 3;
    localparam int LCR_CLK_HZ = 100000000;
    localparam int LCR_PROBE_PERIOD_MS = 12;
    localparam int LCR_PROBE_CYCLES = LCR_PROBE_PERIOD_MS * (LCR_CLK_HZ / 1000);
    localparam logic [5:0] LCR_PROBE_LIMIT = 6'h32;
    typedef enum logic [1:0] {
        LCR_PROBE_OFF,
        LCR_PROBE_LIMITED,
        LCR_PROBE_ENDLESS,
        LCR_PROBE_FORCED
    } lcr_probe_mode_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } lcr_bus_req_t;
    typedef struct packed {
        logic [6:0] assertMv;
        logic [6:0] deassertMv;
        logic [2:0] swingCode;
        logic shortProtect;
        logic [7:0] boost;
    } lcr_analog_t;
endpackage : lcr_pkg
`default_nettype wire

// ===== design/lcr_lane_regs.sv
// Lane configuration registers with timed far-receiver probe sequencer.
`default_nettype none
module lcr_lane_regs #(
    parameter int PROBE_CYCLES = lcr_pkg::LCR_PROBE_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire lcr_pkg::lcr_bus_req_t busReq,
    output logic [7:0] rdData,
    input wire logic ovrThresh,
    input wire logic ovrProbe,
    input wire logic [3:0] threshPin,
    input wire logic [1:0] probePin,
    input wire logic farReceiverSeen,
    output logic probePulse,
    output logic terminated,
    output lcr_pkg::lcr_analog_t analogCfg
);
    logic [7:0] thresh_reg;
    logic [7:0] probe_reg;
    logic [7:0] boost_reg;
    logic [7:0] swing_reg;
    logic [7:0] rsvdLo_reg;
    logic [7:0] rsvdHi_reg;
    logic [7:0] dbLow_reg;
    logic [31:0] tick_reg;
    logic [5:0] tries_reg;
    logic found_reg;
    logic [1:0] ovrT_s1, ovrT_s2;
    logic [1:0] ovrP_s1, ovrP_s2;
    logic [3:0] thPin_s1, thPin_s2;
    logic [1:0] prPin_s1, prPin_s2;
    logic seen_s1, seen_s2;
    logic [3:0] thEff;
    logic [1:0] prEff;
    logic restart;
    logic [6:0] assertMv, deassertMv;

    // Pin-level inputs pass two flip-flops before any logic reads them.
    always_ff @(posedge clk) begin
        ovrT_s1 <= {1'b0, ovrThresh};
        ovrT_s2 <= ovrT_s1;
        ovrP_s1 <= {1'b0, ovrProbe};
        ovrP_s2 <= ovrP_s1;
        thPin_s1 <= threshPin;
        thPin_s2 <= thPin_s1;
        prPin_s1 <= probePin;
        prPin_s2 <= prPin_s1;
        seen_s1 <= farReceiverSeen;
        seen_s2 <= seen_s1;
    end

    // Effective settings follow registers only under the override bits.
    always_comb begin
        thEff = ovrT_s2[0] ? thresh_reg[3:0] : thPin_s2;
        prEff = ovrP_s2[0] ? probe_reg[3:2] : prPin_s2;
    end

    // A write of an automatic setting restarts the sequence.
    assign restart = busReq.wr && busReq.addr == lcr_pkg::LCR_ADDR_PROBE
        && (busReq.wdata[3:2] == 2'b01 || busReq.wdata[3:2] == 2'b10);

    // Register writes; unmapped addresses are ignored.
    always_ff @(posedge clk) begin
        if (srst) begin
            thresh_reg <= lcr_pkg::LCR_RST_THRESH;
            probe_reg <= lcr_pkg::LCR_RST_PROBE;
            boost_reg <= lcr_pkg::LCR_RST_BOOST;
            swing_reg <= lcr_pkg::LCR_RST_SWING;
            rsvdLo_reg <= 8'h00;
            rsvdHi_reg <= 8'h00;
            dbLow_reg <= lcr_pkg::LCR_RST_STATUS;
        end else if (busReq.wr) begin
            case (busReq.addr)
                lcr_pkg::LCR_ADDR_THRESH: thresh_reg <= busReq.wdata;
                lcr_pkg::LCR_ADDR_RSVD_LO: rsvdLo_reg <= busReq.wdata;
                lcr_pkg::LCR_ADDR_RSVD_HI: rsvdHi_reg <= busReq.wdata;
                lcr_pkg::LCR_ADDR_PROBE: probe_reg <= busReq.wdata;
                lcr_pkg::LCR_ADDR_BOOST: boost_reg <= busReq.wdata;
                lcr_pkg::LCR_ADDR_SWING: swing_reg <= busReq.wdata;
                lcr_pkg::LCR_ADDR_STATUS: dbLow_reg <= {1'b0, busReq.wdata[6:0]};
                default: ;
            endcase
        end
    end

    // Read data stands in the cycle after the read strobe only.
    always_ff @(posedge clk) begin
        if (srst || !busReq.rd) begin
            rdData <= 8'h00;
        end else begin
            case (busReq.addr)
                lcr_pkg::LCR_ADDR_THRESH: rdData <= thresh_reg;
                lcr_pkg::LCR_ADDR_RSVD_LO: rdData <= rsvdLo_reg;
                lcr_pkg::LCR_ADDR_RSVD_HI: rdData <= rsvdHi_reg;
                lcr_pkg::LCR_ADDR_PROBE: rdData <= probe_reg;
                lcr_pkg::LCR_ADDR_BOOST: rdData <= boost_reg;
                lcr_pkg::LCR_ADDR_SWING: rdData <= swing_reg;
                lcr_pkg::LCR_ADDR_STATUS: rdData <= {terminated, dbLow_reg[6:0]};
                default: rdData <= 8'h00;
            endcase
        end
    end

    // Probe interval timer: a pulse every 12 ms while an automatic probe runs.
    always_ff @(posedge clk) begin
        if (srst || restart || found_reg) begin
            tick_reg <= 32'h0;
            tries_reg <= 6'h00;
            probePulse <= 1'b0;
        end else if ((prEff == 2'b01 && tries_reg != lcr_pkg::LCR_PROBE_LIMIT)
                || prEff == 2'b10) begin
            probePulse <= 1'b0;
            if (tick_reg == 32'(PROBE_CYCLES - 1)) begin
                tick_reg <= 32'h0;
                probePulse <= 1'b1;
                if (tries_reg != lcr_pkg::LCR_PROBE_LIMIT) begin
                    tries_reg <= tries_reg + 6'h01;
                end
            end else begin
                tick_reg <= tick_reg + 32'h1;
            end
        end else begin
            probePulse <= 1'b0;
        end
    end

    // Detection latch; cleared when the mode leaves automatic or restarts.
    always_ff @(posedge clk) begin
        if (srst || restart || prEff == 2'b00 || prEff == 2'b11) begin
            found_reg <= 1'b0;
        end else if (probePulse && seen_s2) begin
            found_reg <= 1'b1;
        end
    end

    // Termination state seen by the lane input.
    always_ff @(posedge clk) begin
        if (srst) begin
            terminated <= 1'b0;
        end else begin
            case (prEff)
                2'b00: terminated <= 1'b0;
                2'b11: terminated <= 1'b1;
                default: terminated <= found_reg;
            endcase
        end
    end

    // Threshold code to millivolt decode.
    always_comb begin
        case (thEff[3:2])
            2'b00: assertMv = 7'd50;
            2'b01: assertMv = 7'd40;
            2'b10: assertMv = 7'd75;
            default: assertMv = 7'd58;
        endcase
        case (thEff[1:0])
            2'b00: deassertMv = 7'd37;
            2'b01: deassertMv = 7'd22;
            2'b10: deassertMv = 7'd55;
            default: deassertMv = 7'd45;
        endcase
    end

    // Analog settings registered toward the signal path.
    always_ff @(posedge clk) begin
        if (srst) begin
            analogCfg <= '0;
        end else begin
            analogCfg.assertMv <= assertMv;
            analogCfg.deassertMv <= deassertMv;
            analogCfg.swingCode <= swing_reg[2:0];
            analogCfg.shortProtect <= swing_reg[lcr_pkg::LCR_POS_SHORT];
            analogCfg.boost <= boost_reg;
        end
    end
endmodule : lcr_lane_regs
`default_nettype wire

// ===== testbench/lcr_lane_regs_monitor.sv
// Port checker for the lane configuration register slice.
`default_nettype none
module lcr_lane_regs_monitor #(
    parameter int PROBE_CYCLES = 20
) (
    input wire logic clk,
    input wire logic srst,
    input wire lcr_pkg::lcr_bus_req_t busReq,
    input wire logic [7:0] rdData,
    input wire logic ovrProbe,
    input wire logic probePulse,
    input wire logic terminated,
    input wire lcr_pkg::lcr_analog_t analogCfg
);
    logic [7:0] wdOne, wdTwo;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Delays write data so it lines up with the decoded outputs.
    always_ff @(posedge clk) begin
        wdOne <= busReq.wdata;
        wdTwo <= wdOne;
    end
    sequence s_wr(logic [7:0] a);
        busReq.wr && busReq.addr == a ##1 !busReq.wr;
    endsequence
    chk_term_reset: assert property ($fell(srst) |-> !terminated)
        else $error("termination not cleared by reset");
    chk_pulse_gap: assert property (probePulse |-> ##1 (!probePulse) [*8])
        else $error("probe attempts too close");
    chk_pulse_unterm: assert property (probePulse |-> !terminated)
        else $error("probe while terminated");
    chk_boost_apply: assert property (s_wr(8'h24) |=> analogCfg.boost == wdTwo)
        else $error("boost not applied");
    chk_swing_apply: assert property (s_wr(8'h25) |=>
        {analogCfg.shortProtect, analogCfg.swingCode} == {wdTwo[7], wdTwo[2:0]})
        else $error("swing not applied");
    chk_status_read: assert property (busReq.rd && busReq.addr == 8'h26
        |=> rdData[7] == $past(terminated)) else $error("status bit wrong");
    chk_probe_restart: assert property (busReq.wr && busReq.addr == 8'h23 && ovrProbe
        && (busReq.wdata[3] != busReq.wdata[2]) |-> ##[1:3] !terminated)
        else $error("detection not cleared on restart");
    chk_forced_term: assert property (busReq.wr && busReq.addr == 8'h23 && ovrProbe
        && busReq.wdata[3:2] == 2'h3 |-> ##[1:4] terminated)
        else $error("forced termination missing");
endmodule : lcr_lane_regs_monitor
bind lcr_lane_regs lcr_lane_regs_monitor #(.PROBE_CYCLES(PROBE_CYCLES)) mon_u (.clk(clk),
    .srst(srst), .busReq(busReq), .rdData(rdData), .ovrProbe(ovrProbe),
    .probePulse(probePulse), .terminated(terminated), .analogCfg(analogCfg));
`default_nettype wire

// ===== testbench/lcr_far_rx.sv
// Far-side receiver that answers the probe after a set number of attempts.
`default_nettype none
module lcr_far_rx (
    input wire logic clk,
    input wire logic probePulse,
    input wire logic [7:0] answerAfter,
    output logic farReceiverSeen
);
    logic [7:0] seen_reg;
    // Counts attempts while armed; zero disarms and restarts the count.
    always_ff @(posedge clk) begin
        if (answerAfter == 8'h00) seen_reg <= 8'h00;
        else if (probePulse) seen_reg <= seen_reg + 8'h01;
    end
    assign farReceiverSeen = (answerAfter != 8'h00) && (seen_reg >= answerAfter);
endmodule : lcr_far_rx
`default_nettype wire

// ===== testbench/lane_config_regs_rx_detect_test.sv
// Register and probe tests for the lane configuration register slice.
`default_nettype none
module lane_config_regs_rx_detect_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, srst = 1'b1, ovrThresh = 1'b0, ovrProbe = 1'b0, seen, pulse, term;
    logic [3:0] threshPin = 4'h0;
    logic [1:0] probePin = 2'h0;
    logic [7:0] rdData, answerAfter = 8'h00;
    int errors = 0, total_checks = 0, pulses = 0;
    lcr_pkg::lcr_bus_req_t busReq = '0;
    lcr_pkg::lcr_analog_t cfg;
    logic [7:0] rstVal [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h2f, 8'had, 8'h02};
    logic [7:0] amv [4] = '{8'h32, 8'h28, 8'h4b, 8'h3a};
    logic [7:0] dmv [4] = '{8'h25, 8'h16, 8'h37, 8'h2d};
    // Clock of 10 ns and a count of probe attempts.
    always #5 clk = ~clk;
    always @(posedge clk) if (pulse) pulses <= pulses + 1;
    lcr_lane_regs #(.PROBE_CYCLES(20)) dut_u (.clk(clk), .srst(srst), .busReq(busReq),
        .rdData(rdData), .ovrThresh(ovrThresh), .ovrProbe(ovrProbe), .threshPin(threshPin),
        .probePin(probePin), .farReceiverSeen(seen), .probePulse(pulse), .terminated(term),
        .analogCfg(cfg));
    lcr_far_rx far_u (.clk(clk), .probePulse(pulse), .answerAfter(answerAfter),
        .farReceiverSeen(seen));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) busReq <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) busReq.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) busReq <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk) busReq.rd <= 1'b0;
        #1 chk(rdData, exp);
    endtask : rd
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    // Main sequence of register and probe scenarios.
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 7; i++) rd(8'h20 + 8'(i), rstVal[i]);
        rd(8'h30, 8'h00);
        wr(8'h24, 8'h5a);
        wr(8'h25, 8'hae);
        wr(8'h26, 8'hff);
        rd(8'h26, 8'h7f);
        chk({cfg.shortProtect, 4'h0, cfg.swingCode}, 8'h86);
        ovrThresh <= 1'b1;
        for (int c = 0; c < 16; c++) begin
            wr(8'h20, 8'(c));
            repeat (4) @(posedge clk);
            chk({1'b0, cfg.assertMv}, amv[c[3:2]]);
            chk({1'b0, cfg.deassertMv}, dmv[c[1:0]]);
        end
        ovrThresh <= 1'b0;
        threshPin <= 4'h9;
        ovrProbe <= 1'b1;
        repeat (6) @(posedge clk);
        chk({1'b0, cfg.assertMv}, amv[2]);
        #1 pulses = 0;
        wr(8'h23, 8'h04);
        repeat (1100) @(posedge clk);
        chk(8'(pulses), 8'h32);
        chk({7'h00, term}, 8'h00);
        answerAfter <= 8'h03;
        wr(8'h23, 8'h08);
        repeat (200) @(posedge clk);
        rd(8'h26, 8'hff);
        #1 pulses = 0;
        wr(8'h23, 8'h04);
        repeat (2) @(posedge clk);
        chk({7'h00, term}, 8'h00);
        answerAfter <= 8'h00;
        #1 pulses = 0;
        wr(8'h23, 8'h08);
        repeat (1100) @(posedge clk);
        chk({7'h00, pulses > 50}, 8'h01);
        wr(8'h23, 8'h00);
        repeat (60) @(posedge clk);
        chk({7'h00, term}, 8'h00);
        #1 pulses = 0;
        wr(8'h23, 8'h0c);
        repeat (60) @(posedge clk);
        chk({7'h00, term}, 8'h01);
        chk(8'(pulses), 8'h00);
        ovrProbe <= 1'b0;
        repeat (6) @(posedge clk);
        chk({7'h00, term}, 8'h00);
        probePin <= 2'h3;
        repeat (6) @(posedge clk);
        chk({7'h00, term}, 8'h01);
        tally_and_finish();
    end
    // Cuts a hang short far beyond the run of about 2700 cycles.
    initial begin
        #100000;
        errors++;
        tally_and_finish();
    end
endmodule : lane_config_regs_rx_detect_test
`default_nettype wire
